// ==== core/adc_clock_result_event_routing.sv ====
// register bank for clock source, result, sync standby and event pin routing
`timescale 1ns/1ps
`include "adc_routing_map.svh"

//
// Contract
// - mode 1011 toggles convert and standby on each falling frame trigger edge
// - clock select 00: internal oscillator, clock pin not driven
// - clock select 01: internal oscillator, also driven out on clock pin
// - clock select 10: main clock straight from clock pin, 76.8 kHz supplied
// - clock select 11: clock pin carries 153.6 kHz, halved internally
// - 24-bit read-only result holds latest conversion, replaced each completion
// - flush enable set: trigger pulse empties FIFO; clear: FIFO untouched
// - FIFO disabled: data-ready is routed event; else FIFO event
// - routing 00: data-ready to event or dout pin, FIFO event event-pin only
// - routing 01: routed event drives clock pin, over clock output choice
// - routing 10: routed event drives pin zero, over its direction bit
// - routing 11: data-ready to dout pin, FIFO event not routed
module adc_clock_result_event_routing #(
    parameter int OSC_HALF = `OSC_HALF_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion core
    input wire logic conv_done,
    input wire logic [23:0] conv_data,
    output logic converting,
    output logic standby,
    output logic mclk_tick,
    // fifo side
    input wire logic fifo_enabled,
    input wire logic fifo_event,
    output logic fifo_flush,
    // package option, high for ball package
    input wire logic package_ball,
    // frame trigger pin, active low pulses
    input wire logic frame_trigger_n,
    // clock pin
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    // general pin zero
    output logic general_pin_zero_out,
    output logic general_pin_zero_oe,
    // event and data-out pins
    output logic event_pin,
    output logic dout_ready,
    output logic dout_ready_en,
    // interrupt
    output logic irq
);

    logic [`SETUP_WIDTH-1:0] setup_reg;
    logic [`ROUTE_WIDTH-1:0] routing_reg;
    logic [`RESULT_WIDTH-1:0] result_reg;
    logic [`IRQ_WIDTH-1:0] irq_status_reg;
    logic [`IRQ_WIDTH-1:0] irq_mask_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic data_ready_reg;
    logic trig_prev_reg;
    logic flush_reg;
    logic late_conv_reg;
    adc_routing_pkg::seq_state_t seq_reg;
    adc_routing_pkg::seq_state_t seq_next;

    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic rd_done;
    logic [3:0] idx;
    logic idx_mapped;
    logic trig_fall;
    logic sync_mode;
    logic routed_event;
    logic osc_level;
    logic [1:0] mclk_sel;
    adc_routing_pkg::route_sel_t route_sel;
    logic [`IRQ_WIDTH-1:0] irq_events;

    function automatic logic is_mapped(input logic [3:0] i);
        return (i == `IDX_SETUP) || (i == `IDX_RESULT) || (i == `IDX_ROUTING) ||
            (i == `IDX_IRQ_STATUS) || (i == `IDX_IRQ_MASK);
    endfunction

    // apb decode; word aligned, upper address bits must be zero
    assign idx = paddr[5:2];
    assign idx_mapped = is_mapped(idx) && (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable;
    assign wr_en = access_done & pwrite & idx_mapped;
    assign rd_done = access_done & ~pwrite & idx_mapped;
    assign pready = 1'b1;
    assign pslverr = access_done & err_reg;
    assign prdata = rdata_reg;

    assign mclk_sel = setup_reg[`SETUP_MCLK_LSB +: 2];
    assign sync_mode = setup_reg[`SETUP_MODE_LSB +: 4] == `MODE_SYNC_STANDBY;
    assign route_sel = adc_routing_pkg::route_sel_t'(routing_reg[`ROUTE_SEL_LSB +: 2]);
    assign trig_fall = trig_prev_reg & ~frame_trigger_n;

    // read data captured at setup so the whole result word is one snapshot
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else if (setup_phase) begin
            err_reg <= ~idx_mapped;
            rdata_reg <= 32'h00000000;
            // refused addresses read zero, even when the index alone is mapped
            if (!pwrite && idx_mapped) begin
                unique case (idx)
                    `IDX_SETUP: rdata_reg <= {16'h0000, setup_reg};
                    `IDX_RESULT: rdata_reg <= {8'h00, result_reg};
                    `IDX_ROUTING: rdata_reg <= {16'h0000, routing_reg};
                    `IDX_IRQ_STATUS: rdata_reg <= {29'h00000000, irq_status_reg};
                    `IDX_IRQ_MASK: rdata_reg <= {29'h00000000, irq_mask_reg};
                    default: rdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_reg <= `SETUP_RESET;
            routing_reg <= `ROUTE_RESET;
            irq_mask_reg <= 3'h0;
        end else if (wr_en) begin
            unique case (idx)
                `IDX_SETUP: setup_reg <= pwdata[15:0];
                // reserved routing bits stay zero
                `IDX_ROUTING: routing_reg <= pwdata[15:0] & `ROUTE_WMASK;
                `IDX_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // result register, written whole in a single edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= `RESULT_RESET;
        end else if (conv_done) begin
            result_reg <= conv_data;
        end
    end

    // a result landing after the read snapshot was not seen, so data-ready must stay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            late_conv_reg <= 1'b0;
        end else if (setup_phase) begin
            late_conv_reg <= conv_done;
        end else if (conv_done) begin
            late_conv_reg <= 1'b1;
        end
    end

    // data-ready level: set by a conversion, dropped by a result read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_ready_reg <= 1'b0;
        end else if (conv_done) begin
            data_ready_reg <= 1'b1;
        end else if (rd_done && idx == `IDX_RESULT && !late_conv_reg) begin
            data_ready_reg <= 1'b0;
        end
    end

    // frame trigger edge and fifo flush
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_prev_reg <= 1'b1;
            flush_reg <= 1'b0;
        end else begin
            trig_prev_reg <= frame_trigger_n;
            flush_reg <= trig_fall & routing_reg[`ROUTE_FLUSH_BIT];
        end
    end

    // sync standby sequencing
    always_comb begin
        seq_next = seq_reg;
        unique case (seq_reg)
            adc_routing_pkg::SEQ_IDLE: begin
                if (sync_mode) begin
                    seq_next = adc_routing_pkg::SEQ_STANDBY;
                end
            end
            adc_routing_pkg::SEQ_CONVERT: begin
                if (!sync_mode) begin
                    seq_next = adc_routing_pkg::SEQ_IDLE;
                end else if (trig_fall) begin
                    seq_next = adc_routing_pkg::SEQ_STANDBY;
                end
            end
            adc_routing_pkg::SEQ_STANDBY: begin
                if (!sync_mode) begin
                    seq_next = adc_routing_pkg::SEQ_IDLE;
                end else if (trig_fall) begin
                    seq_next = adc_routing_pkg::SEQ_CONVERT;
                end
            end
            default: seq_next = adc_routing_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_reg <= adc_routing_pkg::SEQ_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign converting = seq_reg == adc_routing_pkg::SEQ_CONVERT;
    assign standby = seq_reg == adc_routing_pkg::SEQ_STANDBY;
    assign fifo_flush = flush_reg;

    // main clock
    clk_source_sel #(
        .OSC_HALF(OSC_HALF)
    ) clk_source_sel_inst (
        .clk(clk),
        .arst_n(arst_n),
        .mclk_sel(mclk_sel),
        .clk_pin_in(clk_pin_in),
        .mclk_tick(mclk_tick),
        .osc_level(osc_level)
    );

    // event selection and pin routing
    assign routed_event = fifo_enabled ? fifo_event : data_ready_reg;

    always_comb begin
        clk_pin_out = 1'b0;
        clk_pin_oe = 1'b0;
        general_pin_zero_out = routing_reg[`ROUTE_PIN0_DATA_BIT];
        general_pin_zero_oe = routing_reg[`ROUTE_PIN0_DIR_BIT];
        event_pin = 1'b0;
        dout_ready = 1'b0;
        dout_ready_en = 1'b0;
        if (mclk_sel == 2'(adc_routing_pkg::MCLK_INT_DRIVEN)) begin
            clk_pin_out = osc_level;
            clk_pin_oe = 1'b1;
        end
        unique case (route_sel)
            adc_routing_pkg::ROUTE_DEFAULT: begin
                if (package_ball) begin
                    event_pin = routed_event;
                end else if (!fifo_enabled) begin
                    // lead package: no pin for the fifo event here
                    dout_ready = data_ready_reg;
                    dout_ready_en = 1'b1;
                end
            end
            adc_routing_pkg::ROUTE_CLK_PIN: begin
                // external clock modes would collide with this drive; host's care
                clk_pin_out = routed_event;
                clk_pin_oe = 1'b1;
            end
            adc_routing_pkg::ROUTE_PIN_ZERO: begin
                general_pin_zero_out = routed_event;
                general_pin_zero_oe = 1'b1;
            end
            adc_routing_pkg::ROUTE_DOUT: begin
                dout_ready = data_ready_reg & ~fifo_enabled;
                dout_ready_en = ~fifo_enabled;
            end
        endcase
    end

    // interrupt status: set wins over read-clear
    assign irq_events[`IRQ_DATA_READY] = conv_done;
    assign irq_events[`IRQ_SYNC_EDGE] = trig_fall;
    assign irq_events[`IRQ_FLUSH] = flush_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_reg <= 3'h0;
        end else if (rd_done && idx == `IDX_IRQ_STATUS) begin
            // clear only the bits the snapshot reported, later events survive
            irq_status_reg <= (irq_status_reg & ~rdata_reg[`IRQ_WIDTH-1:0]) | irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

// ==== core/adc_routing_map.svh ====
// register map, field positions, reset values and timing counts
`ifndef ADC_ROUTING_MAP_SVH
`define ADC_ROUTING_MAP_SVH

// register indices; byte address is four times the index
`define IDX_SETUP 4'h1
`define IDX_RESULT 4'h2
`define IDX_ROUTING 4'h3
`define IDX_IRQ_STATUS 4'h8
`define IDX_IRQ_MASK 4'h9

// converter_setup fields
`define SETUP_MCLK_LSB 0
`define SETUP_MODE_LSB 2
`define SETUP_WIDTH 16
`define SETUP_RESET 16'h0000
`define MODE_SYNC_STANDBY 4'hb

// pin_function_routing fields
`define ROUTE_PIN0_DIR_BIT 1
`define ROUTE_PIN0_DATA_BIT 4
`define ROUTE_SEL_LSB 8
`define ROUTE_FLUSH_BIT 10
`define ROUTE_WIDTH 16
`define ROUTE_RESET 16'h0000
`define ROUTE_WMASK 16'h0712

// conversion_result
`define RESULT_WIDTH 24
`define RESULT_RESET 24'h000000

// interrupt status bits
`define IRQ_DATA_READY 0
`define IRQ_SYNC_EDGE 1
`define IRQ_FLUSH 2
`define IRQ_WIDTH 3

// timing
`define SYS_CLK_HZ 200000000
`define OSC_HZ 76800
`define OSC_HALF_CYCLES (`SYS_CLK_HZ / (2 * `OSC_HZ))

`endif

// ==== core/adc_routing_pkg.sv ====
// types shared by the clock and routing logic
package adc_routing_pkg;

    typedef enum logic [1:0] {
        MCLK_INT_QUIET = 2'h0,
        MCLK_INT_DRIVEN = 2'h1,
        MCLK_EXT_DIRECT = 2'h2,
        MCLK_EXT_HALVED = 2'h3
    } mclk_src_t;

    typedef enum logic [1:0] {
        ROUTE_DEFAULT = 2'h0,
        ROUTE_CLK_PIN = 2'h1,
        ROUTE_PIN_ZERO = 2'h2,
        ROUTE_DOUT = 2'h3
    } route_sel_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_CONVERT = 3'h2,
        SEQ_STANDBY = 3'h4
    } seq_state_t;

endpackage

// ==== core/clk_source_sel.sv ====
// main clock source: internal oscillator or clock pin, optional halving
`timescale 1ns/1ps
`include "adc_routing_map.svh"

module clk_source_sel #(
    parameter int OSC_HALF = `OSC_HALF_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic [1:0] mclk_sel,
    // clock pin level, sampled
    input wire logic clk_pin_in,
    // results
    output logic mclk_tick,
    output logic osc_level
);

    logic [11:0] osc_cnt_reg;
    logic osc_level_reg;
    logic pin_prev_reg;
    logic halve_reg;
    logic tick_reg;
    logic pin_rise;
    logic osc_rise;

    assign pin_rise = clk_pin_in & ~pin_prev_reg;
    assign osc_rise = (osc_cnt_reg == 12'(OSC_HALF - 1)) & ~osc_level_reg;

    // oscillator stand-in, free running so clock-out never glitches on a mode switch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt_reg <= 12'h000;
            osc_level_reg <= 1'b0;
        end else if (osc_cnt_reg == 12'(OSC_HALF - 1)) begin
            osc_cnt_reg <= 12'h000;
            osc_level_reg <= ~osc_level_reg;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_prev_reg <= 1'b0;
            halve_reg <= 1'b0;
        end else begin
            pin_prev_reg <= clk_pin_in;
            if (pin_rise) begin
                halve_reg <= ~halve_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_reg <= 1'b0;
        end else begin
            unique case (adc_routing_pkg::mclk_src_t'(mclk_sel))
                adc_routing_pkg::MCLK_INT_QUIET: tick_reg <= osc_rise;
                adc_routing_pkg::MCLK_INT_DRIVEN: tick_reg <= osc_rise;
                adc_routing_pkg::MCLK_EXT_DIRECT: tick_reg <= pin_rise;
                adc_routing_pkg::MCLK_EXT_HALVED: tick_reg <= pin_rise & halve_reg;
            endcase
        end
    end

    assign mclk_tick = tick_reg;
    assign osc_level = osc_level_reg;

endmodule

// ==== dv/adc_routing_sva.sv ====
// concurrent checks on the register bank's pins
`timescale 1ns/1ps

module adc_routing_sva (
    // system
    input wire logic clk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // core and pins
    input wire logic converting,
    input wire logic standby,
    input wire logic mclk_tick,
    input wire logic fifo_enabled,
    input wire logic fifo_flush,
    input wire logic package_ball,
    input wire logic frame_trigger_n,
    input wire logic event_pin,
    input wire logic dout_ready_en,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    standby_to_conv_a: assert property (
        $fell(frame_trigger_n) && standby |=> converting && !standby)
        else $error("sync edge did not leave standby");
    conv_to_standby_a: assert property (
        $fell(frame_trigger_n) && converting |=> standby && !converting)
        else $error("sync edge did not enter standby");
    seq_excl_a: assert property (!(converting && standby))
        else $error("convert and standby together");
    flush_cause_a: assert property (
        fifo_flush |-> $past(frame_trigger_n, 2) && !$past(frame_trigger_n, 1))
        else $error("flush without a sync edge");
    flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
        else $error("flush longer than one cycle");
    tick_pulse_a: assert property (mclk_tick |=> !mclk_tick)
        else $error("main clock tick too long");
    dout_en_a: assert property (dout_ready_en |-> !fifo_enabled)
        else $error("fifo event routed to data-out pin");
    event_pkg_a: assert property (event_pin |-> package_ball)
        else $error("event pin active on lead package");
    read_hold_a: assert property (psel && penable |=> $stable(prdata))
        else $error("read data changed after access");
    addr_error_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");

    cover property (fifo_flush);
    cover property (converting);
    cover property (irq);
    cover property (pslverr);
endmodule

// ==== dv/clk_pin_source.sv ====
// external clock source driving the clock pin
`timescale 1ns/1ps

module clk_pin_source #(
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic fast,
    input wire logic en,
    output logic pin
);
    int cnt = 0;
    logic level = 1'h0;
    assign pin = level;
    // fast doubles the rate, as the halving mode expects; en low parks the pin
    always @(posedge clk) begin
        cnt <= (cnt >= (fast ? HALF / 2 : HALF) - 1) ? 0 : cnt + 1;
        if (en && cnt == 0) level <= ~level;
    end
endmodule

// ==== dv/test_adc_clock_result_event_routing.sv ====
// testbench for the clock, result and event routing register bank
`timescale 1ns/1ps
`include "adc_routing_map.svh"

module test_adc_clock_result_event_routing;
    localparam logic [7:0] A_SET = {2'h0, `IDX_SETUP, 2'h0};
    localparam logic [7:0] A_RES = {2'h0, `IDX_RESULT, 2'h0};
    localparam logic [7:0] A_RT = {2'h0, `IDX_ROUTING, 2'h0};
    localparam logic [7:0] A_ST = {2'h0, `IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_MSK = {2'h0, `IDX_IRQ_MASK, 2'h0};
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e;
    logic conv_done = 1'h0, fifo_enabled = 1'h0, fifo_event = 1'h0;
    logic package_ball = 1'h0, frame_trigger_n = 1'h1;
    logic [23:0] conv_data = 24'h0;
    logic src_fast = 1'h0, src_en = 1'h0, src_pin;
    logic converting, standby, mclk_tick, fifo_flush, clk_pin_out, clk_pin_oe;
    logic general_pin_zero_out, general_pin_zero_oe, event_pin;
    logic dout_ready, dout_ready_en, irq;
    int fails = 0, n_checks = 0, n_ticks = 0, n_flush = 0, t0;
    // level on the clock pin: ours when driving, else the source's
    wire clk_pin_wire = clk_pin_oe ? clk_pin_out : src_pin;

    adc_clock_result_event_routing #(.OSC_HALF(4)) adc_clock_result_event_routing_inst (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_data(conv_data), .converting(converting),
        .standby(standby), .mclk_tick(mclk_tick), .fifo_enabled(fifo_enabled),
        .fifo_event(fifo_event), .fifo_flush(fifo_flush), .package_ball(package_ball),
        .frame_trigger_n(frame_trigger_n), .clk_pin_in(clk_pin_wire),
        .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
        .general_pin_zero_out(general_pin_zero_out),
        .general_pin_zero_oe(general_pin_zero_oe), .event_pin(event_pin),
        .dout_ready(dout_ready), .dout_ready_en(dout_ready_en), .irq(irq)
    );
    clk_pin_source #(.HALF(4)) clk_pin_source_inst (
        .clk(clk),
        .fast(src_fast),
        .en(src_en),
        .pin(src_pin)
    );

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (mclk_tick === 1'h1) n_ticks++;
        if (fifo_flush === 1'h1) n_flush++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
        n_checks++;
        if (got !== x) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
        apb(1'h0, a, 32'h0);
        chk(q, x, m);
    endtask
    task automatic conv(input logic [23:0] d);
        @(posedge clk);
        conv_done <= 1'h1;
        conv_data <= d;
        @(posedge clk);
        conv_done <= 1'h0;
    endtask
    task automatic sync_pulse;
        @(posedge clk);
        frame_trigger_n <= 1'h0;
        cyc(4);
        frame_trigger_n <= 1'h1;
        cyc(4);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        cyc(6);
        arst_n <= 1'h1;
        rd(A_RES, 32'h0, "result reset");
        rd(A_RT, 32'h0, "routing reset");
        rd(8'h14, 32'h0, "unmapped read");
        chk(e, 32'h1, "unmapped error");
        wr(A_RT, 32'hffffffff);
        rd(A_RT, `ROUTE_WMASK, "routing write mask");
        wr(A_RT, 32'h0);
        $display("test reset_map done");
        conv(24'habcdef);
        cyc(1);
        chk(dout_ready, 32'h1, "data ready on dout");
        rd(8'h09, 32'h0, "misaligned read");
        chk(e, 32'h1, "misaligned error");
        rd(8'h48, 32'h0, "upper address read");
        chk(e, 32'h1, "upper address error");
        wr(A_RES, 32'hffffffff);
        rd(A_RES, 32'h00abcdef, "result kept");
        cyc(1);
        chk(dout_ready, 32'h0, "data ready cleared");
        conv(24'h123456);
        rd(A_RES, 32'h00123456, "result replaced");
        $display("test result done");
        fifo_enabled <= 1'h1;
        fifo_event <= 1'h1;
        package_ball <= 1'h1;
        for (int s = 0; s < 4; s++) begin
            wr(A_RT, 32'(s) << 8);
            cyc(1);
            chk(event_pin, 32'(s == 0), "event pin");
            chk(clk_pin_oe, 32'(s == 1), "clock pin route");
            chk(general_pin_zero_oe, 32'(s == 2), "pin zero route");
            chk(dout_ready_en, 32'h0, "fifo event off dout");
        end
        wr(A_RT, 32'h212);
        fifo_event <= 1'h0;
        cyc(2);
        chk(general_pin_zero_out, 32'h0, "pin zero overridden");
        wr(A_SET, 32'h1);
        wr(A_RT, 32'h100);
        cyc(5);
        chk(clk_pin_out, 32'h0, "clock out overridden");
        cyc(4);
        chk(clk_pin_out, 32'h0, "clock out overridden");
        wr(A_SET, 32'h0);
        wr(A_RT, 32'h0);
        fifo_enabled <= 1'h0;
        fifo_event <= 1'h1;
        cyc(2);
        chk(event_pin, 32'h0, "data ready replaces fifo event");
        conv(24'h000001);
        cyc(1);
        chk(event_pin, 32'h1, "data ready as event");
        wr(A_RT, 32'h300);
        cyc(1);
        chk(dout_ready, 32'h1, "data ready on dout route");
        $display("test routing done");
        for (int s = 0; s < 4; s++) begin
            wr(A_SET, s);
            src_en <= s[1];
            src_fast <= (s == 3);
            cyc(20);
            t0 = n_ticks;
            cyc(80);
            chk(32'((n_ticks - t0) inside {[9:11]}), 32'h1, "tick rate");
            chk(clk_pin_oe, 32'(s == 1), "clock pin drive");
        end
        src_en <= 1'h0;
        cyc(20);
        t0 = n_ticks;
        cyc(40);
        chk(n_ticks - t0, 32'h0, "external clock only");
        wr(A_SET, 32'h0);
        $display("test clock done");
        wr(A_RT, 32'h400);
        wr(A_SET, `MODE_SYNC_STANDBY << `SETUP_MODE_LSB);
        cyc(2);
        chk(standby, 32'h1, "enter standby");
        t0 = n_flush;
        sync_pulse;
        chk(converting, 32'h1, "convert on sync");
        chk(n_flush - t0, 32'h1, "flush on sync");
        wr(A_RT, 32'h0);
        sync_pulse;
        chk(standby, 32'h1, "back to standby");
        chk(n_flush - t0, 32'h1, "no flush when off");
        wr(A_SET, 32'h0);
        $display("test sync done");
        wr(A_MSK, 32'h7);
        rd(A_ST, 32'h7, "status sticky bits");
        conv(24'h000002);
        cyc(1);
        chk(irq, 32'h1, "irq raised");
        rd(A_ST, 32'h1, "status done bit");
        cyc(1);
        chk(irq, 32'h0, "irq cleared by read");
        wr(A_MSK, 32'h0);
        conv(24'h000003);
        cyc(1);
        chk(irq, 32'h0, "irq masked");
        rd(A_ST, 32'h1, "status while masked");
        $display("test irq done");
        complete_run;
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("MISMATCH %0t timeout", $time);
        complete_run;
    end
endmodule

bind adc_clock_result_event_routing adc_routing_sva adc_routing_sva_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pslverr(pslverr), .converting(converting), .standby(standby),
    .mclk_tick(mclk_tick), .fifo_enabled(fifo_enabled), .fifo_flush(fifo_flush),
    .package_ball(package_ball), .frame_trigger_n(frame_trigger_n),
    .event_pin(event_pin), .dout_ready_en(dout_ready_en), .irq(irq)
);
